// ==== pkg/sxs_pkg.sv ====
`default_nettype none
package sxs_pkg;
	// Clock rates and documented times.
	localparam int CLK_HZ        = 40_000_000;
	localparam int RC_HZ         = 67_000;
	localparam int RC_START_US   = 100;
	localparam int RC_START_CYC  = (RC_START_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int DEB_MIN_MS    = 470;
	localparam int DEB_MAX_MS    = 480;
	localparam int DEB_MIN_TICKS = (DEB_MIN_MS * RC_HZ + 999) / 1000;
	localparam int DEB_MAX_TICKS = (DEB_MAX_MS * RC_HZ) / 1000;
	localparam int DEB_STEPS     = 6;
	localparam int DEB_STEP_TICKS = (DEB_MAX_TICKS - DEB_MIN_TICKS) / DEB_STEPS;
	localparam int SCK_HALF_CYC  = 4;
	localparam int LATCH_WAIT    = 2;
	localparam int FRAME_MAX     = 64;
	localparam int BUF_DEPTH     = 2;
	// Memory layout and command codes.
	localparam logic [7:0] CMD_READ   = 8'h03;
	localparam logic [7:0] FIFO_CODE  = 8'h95;
	localparam logic [7:0] EMPTY_BYTE = 8'hff;
	localparam logic [7:0] REPEAT_MAX = 8'hfe;
	localparam int         CMD_FLAG   = 7;
	localparam logic [6:0] CFG_LAST   = 7'h4c;
	localparam logic [9:0] SEC_BASE   = 10'h04d;
	localparam logic [3:0] EOL_SLOT   = 4'he;
	// Sequencer states.
	typedef enum logic [3:0] {
		ST_LATCH, ST_MCU, ST_OPEN, ST_CFG, ST_SLEEP,
		ST_WAKE, ST_DEB, ST_SEC, ST_PAY, ST_SEND
	} sxs_state_type;
endpackage
`default_nettype wire

// ==== pkg/sxs_stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sxs_stream_if #(parameter int W = 9);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hdl/sxs_buf.sv ====
`timescale 1ns/10ps
`default_nettype none
module sxs_buf #(
	parameter int W     = 9,
	parameter int DEPTH = sxs_pkg::BUF_DEPTH
) (
	input wire logic   mclk,
	input wire logic   rstn,
	sxs_stream_if.snk  in_s,
	sxs_stream_if.src  out_s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	if (DEPTH < 2) begin : g_chk
		$error("Buffer depth must be at least two.");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   n_q, n_d;
	logic          push, pop;

	// Ready falls when full, so a stalled sink holds the source back.
	assign in_s.ready  = (n_q != FULL);
	assign out_s.valid = (n_q != '0);
	assign out_s.data  = mem_q[rp_q];

	// Pointer and fill level arithmetic.
	always_comb begin
		push = in_s.valid && (n_q != FULL);
		pop  = out_s.ready && (n_q != '0);
		wp_d = push ? ((wp_q == LAST) ? '0 : wp_q + AW'(1)) : wp_q;
		rp_d = pop ? ((rp_q == LAST) ? '0 : rp_q + AW'(1)) : rp_q;
		n_d  = n_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Pointers and fill level.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wp_q <= '0;
			rp_q <= '0;
			n_q  <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			n_q  <= n_d;
		end
	end

	// Entries are written only on an accepted push.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wp_q] <= in_s.data;
		end
	end
endmodule
`default_nettype wire

// ==== hdl/sxs_seq.sv ====
// Behaviour
// - Mode pin high: SPI master, sequencer runs.
// - Power-up reads config section, then sleeps.
// - Button edge in sleep wakes, starts RC.
// - RC-clocked debounce delivers value after delay.
// - Read button section, apply its register writes.
// - Transmit payload, repeats up to 254.
// - Frame done: lock output low, sleep.
// - First 77 bytes are address/value pairs.
// - Section address from slot and section size.
// - Frame at most 64 bytes, 8 kbit memory.
// - Up to 15 sections with register writes.
// - Section: code 0x95, repeat, length, payload.
// - Send repeat-count frames of length bytes.
// - Three-bit debounce select, one setting disables.
// - Button code to slot mapping table.
// - Stored command byte is address plus 0x80.
// - First section starts at location 0x4D.
// - Mode latched once after reset only.
// - Standard SPI read command, up to 8 kbit.
// - Low battery adds slot 14 frame once.
`timescale 1ns/10ps
`default_nettype none
module sxs_seq #(
	parameter int SCK_HALF = sxs_pkg::SCK_HALF_CYC,
	parameter int DEB_MIN  = sxs_pkg::DEB_MIN_TICKS,
	parameter int DEB_STEP = sxs_pkg::DEB_STEP_TICKS,
	parameter int RC_START = sxs_pkg::RC_START_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       app_mode_select_pin,
	input  wire logic [3:0] button_inputs,
	input  wire logic       rc_clk,
	input  wire logic       low_batt,
	input  wire logic       eol_enable,
	input  wire logic [2:0] debounce_time,
	input  wire logic [5:0] section_size,
	input  wire logic       spi_miso,
	output logic            spi_cs_n,
	output logic            spi_sck,
	output logic            spi_mosi,
	output logic            reg_wr,
	output logic [6:0]      reg_addr,
	output logic [7:0]      reg_data,
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	output logic            tx_last,
	input  wire logic       tx_ready,
	output logic            pll_lock,
	output logic            rc_osc_en,
	output logic            sleeping,
	output logic            standalone
);
	if (SCK_HALF < 3 || SCK_HALF > 15 || RC_START < 1 || RC_START > 65535 ||
		DEB_MIN < 1 || DEB_MIN + sxs_pkg::DEB_STEPS * DEB_STEP > 65535) begin : g_chk
		$error("Timing parameters out of range.");
	end

	sxs_stream_if #(.W(9)) buf_in ();
	sxs_stream_if #(.W(9)) buf_out ();

	sxs_buf #(.W(9), .DEPTH(sxs_pkg::BUF_DEPTH)) u_buf (
		.mclk  (mclk),
		.rstn  (rstn),
		.in_s  (buf_in),
		.out_s (buf_out)
	);

	// Slot of a button combination; zero has no slot.
	function automatic logic [3:0] slot_of(input logic [3:0] b);
		logic [3:0] s;
		s = 4'h0;
		unique case (b)
			4'h0: s = 4'h0;
			4'h1: s = 4'h0;
			4'h2: s = 4'h1;
			4'h4: s = 4'h2;
			4'h8: s = 4'h3;
			4'h3: s = 4'h4;
			4'h5: s = 4'h5;
			4'h6: s = 4'h6;
			4'h9: s = 4'h7;
			4'ha: s = 4'h8;
			4'hc: s = 4'h9;
			4'h7: s = 4'ha;
			4'hb: s = 4'hb;
			4'hd: s = 4'hc;
			4'he: s = 4'hd;
			4'hf: s = 4'he;
		endcase
		return s;
	endfunction

	// Section start: base plus slot times (size + 1) bytes.
	function automatic logic [9:0] sec_addr(input logic [3:0] s, input logic [5:0] z);
		logic [10:0] off;
		off = {7'h00, s} * ({5'h00, z} + 11'h001);
		return sxs_pkg::SEC_BASE + off[9:0];
	endfunction

	// Two-stage synchronisers for the mode, battery, oscillator, data and button pins.
	logic [7:0] sync_a_q, sync_s_q;
	logic [3:0] btn_p_q;
	logic       rc_p_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync_a_q <= '0;
			sync_s_q <= '0;
			btn_p_q  <= '0;
			rc_p_q   <= 1'b0;
		end else begin
			sync_a_q <= {app_mode_select_pin, low_batt, rc_clk, spi_miso, button_inputs};
			sync_s_q <= sync_a_q;
			btn_p_q  <= sync_s_q[3:0];
			rc_p_q   <= sync_s_q[5];
		end
	end

	logic [3:0] btn_s;
	logic       miso_s, rc_rise, lowbat_s, mode_s;
	assign btn_s    = sync_s_q[3:0];
	assign miso_s   = sync_s_q[4];
	assign rc_rise  = sync_s_q[5] && !rc_p_q;
	assign lowbat_s = sync_s_q[6];
	assign mode_s   = sync_s_q[7];

	sxs_pkg::sxs_state_type st_q, st_d;
	logic [6:0]  cnt_q, cnt_d, len_q, len_d;
	logic [15:0] tick_q, tick_d;
	logic [9:0]  addr_q, addr_d;
	logic [7:0]  ab_q, ab_d, rep_q, rep_d, tx_q, tx_d, rx_q, rx_d, wd_q, wd_d;
	logic [6:0]  wa_q, wa_d;
	logic [3:0]  snap_q, snap_d, div_q, div_d;
	logic [2:0]  bit_q, bit_d;
	logic [1:0]  ph_q, ph_d;
	logic        busy_q, busy_d, ok_q, ok_d, sck_q, sck_d, cs_n_q, cs_n_d;
	logic        sec_q, sec_d, wr_q, wr_d, lock_q, lock_d, rc_q, rc_d;
	logic        slp_q, slp_d, mode_q, mode_d, eol_q, eol_d, lb_q, lb_d;
	logic [7:0]  pay_q [sxs_pkg::FRAME_MAX];
	logic        mem_we, rd_st, push, f_last;
	logic [15:0] lim;
	logic [3:0]  val;

	assign f_last       = (cnt_q == len_q - 7'h01);
	assign buf_in.valid = (st_q == sxs_pkg::ST_SEND) && (rep_q != 8'h00);
	assign buf_in.data  = {f_last, pay_q[cnt_q[5:0]]};
	assign buf_out.ready = tx_ready;
	assign push = buf_in.valid && buf_in.ready;
	assign rd_st = (st_q == sxs_pkg::ST_OPEN) || (st_q == sxs_pkg::ST_CFG) ||
		(st_q == sxs_pkg::ST_SEC) || (st_q == sxs_pkg::ST_PAY);
	assign lim = 16'(DEB_MIN + (int'(debounce_time) - 1) * DEB_STEP);
	assign val = (debounce_time == 3'h0) ? btn_s : snap_q;

	// Byte engine on SPI mode 0 plus the stand-alone sequencer.
	always_comb begin
		st_d = st_q; cnt_d = cnt_q; len_d = len_q; tick_d = tick_q; addr_d = addr_q;
		ab_d = ab_q; rep_d = rep_q; tx_d = tx_q; rx_d = rx_q; wd_d = wd_q; wa_d = wa_q;
		snap_d = snap_q; div_d = div_q; bit_d = bit_q; ph_d = ph_q; busy_d = busy_q;
		sck_d = sck_q; cs_n_d = cs_n_q; sec_d = sec_q; lock_d = lock_q; rc_d = rc_q;
		slp_d = slp_q; mode_d = mode_q; eol_d = eol_q; lb_d = lb_q;
		ok_d = 1'b0;
		wr_d = 1'b0;
		mem_we = 1'b0;
		// Shift one byte: sample on the rising edge, change on the falling one.
		if (busy_q) begin
			if (div_q == 4'(SCK_HALF - 1)) begin
				div_d = 4'h0;
				if (!sck_q) begin
					sck_d = 1'b1;
					rx_d = {rx_q[6:0], miso_s};
				end else begin
					sck_d = 1'b0;
					if (bit_q == 3'h7) begin
						busy_d = 1'b0;
						ok_d = 1'b1;
					end else begin
						bit_d = bit_q + 3'h1;
						tx_d = {tx_q[6:0], 1'b0};
					end
				end
			end else begin
				div_d = div_q + 4'h1;
			end
		end else if (rd_st && !ok_q) begin
			busy_d = 1'b1;
			div_d = 4'h0;
			bit_d = 3'h0;
			tx_d = 8'h00;
			if (st_q == sxs_pkg::ST_OPEN) begin
				unique case (cnt_q[1:0])
					2'h0: tx_d = sxs_pkg::CMD_READ;
					2'h1: tx_d = {6'h00, addr_q[9:8]};
					default: tx_d = addr_q[7:0];
				endcase
			end
		end
		unique case (st_q)
			sxs_pkg::ST_LATCH: begin
				cnt_d = cnt_q + 7'h01;
				if (cnt_q == 7'(sxs_pkg::LATCH_WAIT)) begin
					mode_d = mode_s;
					cnt_d = 7'h00;
					addr_d = 10'h000;
					sec_d = 1'b0;
					cs_n_d = !mode_s;
					st_d = mode_s ? sxs_pkg::ST_OPEN : sxs_pkg::ST_MCU;
				end
			end
			sxs_pkg::ST_MCU: begin
				st_d = sxs_pkg::ST_MCU;
			end
			sxs_pkg::ST_OPEN: begin
				if (ok_q) begin
					cnt_d = cnt_q + 7'h01;
					if (cnt_q == 7'h02) begin
						cnt_d = 7'h00;
						ph_d = 2'h0;
						st_d = sec_q ? sxs_pkg::ST_SEC : sxs_pkg::ST_CFG;
					end
				end
			end
			sxs_pkg::ST_CFG: begin
				if (ok_q) begin
					cnt_d = cnt_q + 7'h01;
					if (!cnt_q[0]) begin
						ab_d = rx_q;
					end else if (ab_q[sxs_pkg::CMD_FLAG] && ab_q != sxs_pkg::EMPTY_BYTE) begin
						wr_d = 1'b1;
						wa_d = ab_q[6:0];
						wd_d = rx_q;
					end
					if (cnt_q == sxs_pkg::CFG_LAST) begin
						cs_n_d = 1'b1;
						slp_d = 1'b1;
						st_d = sxs_pkg::ST_SLEEP;
					end
				end
			end
			sxs_pkg::ST_SLEEP: begin
				if (btn_s != btn_p_q) begin
					rc_d = 1'b1;
					slp_d = 1'b0;
					tick_d = 16'h0000;
					eol_d = 1'b0;
					lb_d = 1'b0;
					st_d = sxs_pkg::ST_WAKE;
				end
			end
			sxs_pkg::ST_WAKE: begin
				tick_d = tick_q + 16'h0001;
				if (tick_q == 16'(RC_START - 1)) begin
					tick_d = 16'h0000;
					snap_d = btn_s;
					st_d = sxs_pkg::ST_DEB;
				end
			end
			sxs_pkg::ST_DEB: begin
				if (debounce_time == 3'h0 || (rc_rise && btn_s == snap_q && tick_q == lim)) begin
					if (val == 4'h0) begin
						rc_d = 1'b0;
						slp_d = 1'b1;
						st_d = sxs_pkg::ST_SLEEP;
					end else begin
						addr_d = sec_addr(slot_of(val), section_size);
						sec_d = 1'b1;
						cs_n_d = 1'b0;
						cnt_d = 7'h00;
						st_d = sxs_pkg::ST_OPEN;
					end
				end else if (rc_rise) begin
					if (btn_s != snap_q) begin
						snap_d = btn_s;
						tick_d = 16'h0000;
					end else begin
						tick_d = tick_q + 16'h0001;
					end
				end
			end
			sxs_pkg::ST_SEC: begin
				if (ok_q) begin
					unique case (ph_q)
						2'h0: begin
							if (rx_q == sxs_pkg::FIFO_CODE) begin
								ph_d = 2'h2;
							end else if (rx_q[sxs_pkg::CMD_FLAG]) begin
								ab_d = rx_q;
								ph_d = 2'h1;
							end else begin
								cs_n_d = 1'b1;
								lock_d = 1'b0;
								rc_d = 1'b0;
								slp_d = 1'b1;
								st_d = sxs_pkg::ST_SLEEP;
							end
						end
						2'h1: begin
							wr_d = 1'b1;
							wa_d = ab_q[6:0];
							wd_d = rx_q;
							ph_d = 2'h0;
						end
						2'h2: begin
							rep_d = (rx_q > sxs_pkg::REPEAT_MAX) ? sxs_pkg::REPEAT_MAX : rx_q;
							if (eol_q) begin
								rep_d = 8'h01;
							end
							ph_d = 2'h3;
						end
						default: begin
							len_d = (rx_q > 8'(sxs_pkg::FRAME_MAX)) ?
								7'(sxs_pkg::FRAME_MAX) : rx_q[6:0];
							cnt_d = 7'h00;
							lock_d = 1'b1;
							if (rx_q == 8'h00) begin
								rep_d = 8'h00;
								cs_n_d = 1'b1;
								st_d = sxs_pkg::ST_SEND;
							end else begin
								st_d = sxs_pkg::ST_PAY;
							end
						end
					endcase
				end
			end
			sxs_pkg::ST_PAY: begin
				if (ok_q) begin
					mem_we = 1'b1;
					cnt_d = cnt_q + 7'h01;
					if (f_last) begin
						cnt_d = 7'h00;
						cs_n_d = 1'b1;
						st_d = sxs_pkg::ST_SEND;
					end
				end
			end
			sxs_pkg::ST_SEND: begin
				lb_d = lb_q | lowbat_s;
				if (rep_q != 8'h00) begin
					if (push) begin
						cnt_d = cnt_q + 7'h01;
						if (f_last) begin
							cnt_d = 7'h00;
							rep_d = rep_q - 8'h01;
						end
					end
				end else if (!buf_out.valid) begin
					if (eol_enable && lb_q && !eol_q) begin
						eol_d = 1'b1;
						addr_d = sec_addr(sxs_pkg::EOL_SLOT, section_size);
						cs_n_d = 1'b0;
						cnt_d = 7'h00;
						st_d = sxs_pkg::ST_OPEN;
					end else begin
						lock_d = 1'b0;
						rc_d = 1'b0;
						slp_d = 1'b1;
						st_d = sxs_pkg::ST_SLEEP;
					end
				end
			end
			default: begin
				st_d = sxs_pkg::ST_SLEEP;
			end
		endcase
	end

	// Sequencer and engine registers.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= sxs_pkg::ST_LATCH; cnt_q <= '0; len_q <= '0; tick_q <= '0; addr_q <= '0;
			ab_q <= '0; rep_q <= '0; tx_q <= '0; rx_q <= '0; wd_q <= '0; wa_q <= '0;
			snap_q <= '0; div_q <= '0; bit_q <= '0; ph_q <= '0; busy_q <= 1'b0; ok_q <= 1'b0;
			sck_q <= 1'b0; cs_n_q <= 1'b1; sec_q <= 1'b0; wr_q <= 1'b0; lock_q <= 1'b0;
			rc_q <= 1'b0; slp_q <= 1'b0; mode_q <= 1'b0; eol_q <= 1'b0; lb_q <= 1'b0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; len_q <= len_d; tick_q <= tick_d; addr_q <= addr_d;
			ab_q <= ab_d; rep_q <= rep_d; tx_q <= tx_d; rx_q <= rx_d; wd_q <= wd_d; wa_q <= wa_d;
			snap_q <= snap_d; div_q <= div_d; bit_q <= bit_d; ph_q <= ph_d; busy_q <= busy_d;
			ok_q <= ok_d; sck_q <= sck_d; cs_n_q <= cs_n_d; sec_q <= sec_d; wr_q <= wr_d;
			lock_q <= lock_d; rc_q <= rc_d; slp_q <= slp_d; mode_q <= mode_d;
			eol_q <= eol_d; lb_q <= lb_d;
		end
	end

	// Payload store, replayed once per repeat.
	always_ff @(posedge mclk) begin
		if (mem_we) begin
			pay_q[cnt_q[5:0]] <= rx_q;
		end
	end

	// Outputs come from registers here or in the buffer.
	assign spi_cs_n   = cs_n_q;
	assign spi_sck    = sck_q;
	assign spi_mosi   = tx_q[7];
	assign reg_wr     = wr_q;
	assign reg_addr   = wa_q;
	assign reg_data   = wd_q;
	assign tx_valid   = buf_out.valid;
	assign tx_data    = buf_out.data[7:0];
	assign tx_last    = buf_out.data[8];
	assign pll_lock   = lock_q;
	assign rc_osc_en  = rc_q;
	assign sleeping   = slp_q;
	assign standalone = mode_q;
endmodule
`default_nettype wire

// ==== sim/sxs_seq_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// Watches the sequencer pins for slips in link framing, handshakes and sleep state.
module sxs_seq_properties (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic [3:0] button_inputs,
	input wire logic       spi_cs_n,
	input wire logic       spi_sck,
	input wire logic       spi_mosi,
	input wire logic       reg_wr,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic       tx_last,
	input wire logic       tx_ready,
	input wire logic       pll_lock,
	input wire logic       rc_osc_en,
	input wire logic       sleeping,
	input wire logic       standalone
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Sleep means the memory is deselected, the oscillator off and the lock indicator low.
	property p_sleep_off; sleeping |-> spi_cs_n && !pll_lock && !rc_osc_en; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("Active while asleep.");
	// A button edge in sleep starts the oscillator within a few cycles.
	property p_wake; sleeping && $changed(button_inputs) |-> ##[1:6] (rc_osc_en && !sleeping); endproperty
	a_wake: assert property (p_wake) else $error("No wake after button edge.");
	// A register write is a single pulse inside a memory read.
	property p_reg_pulse; reg_wr |-> !spi_cs_n ##1 !reg_wr; endproperty
	a_reg_pulse: assert property (p_reg_pulse) else $error("Bad register write pulse.");
	// The serial clock idles low while the memory is deselected.
	property p_sck_idle; spi_cs_n |-> !spi_sck; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("Serial clock active unselected.");
	// Outgoing data only moves while the serial clock is low.
	property p_mosi_hold; spi_sck |-> $stable(spi_mosi); endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("Data moved with clock high.");
	// A refused payload byte stays put until taken.
	property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("Payload byte dropped or changed.");
	// Payload only flows while the lock indicator is up.
	property p_tx_lock; tx_valid |-> pll_lock; endproperty
	a_tx_lock: assert property (p_tx_lock) else $error("Payload without lock indicator.");
	// The latched mode never drops outside reset.
	property p_mode_keep; 1'b1 |-> !$fell(standalone); endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("Mode changed without reset.");
	// Only the stand-alone mode selects the memory.
	property p_mcu_quiet; $fell(spi_cs_n) |-> standalone; endproperty
	a_mcu_quiet: assert property (p_mcu_quiet) else $error("Memory selected in host mode.");
endmodule
`default_nettype wire

// ==== sim/sxs_eeprom_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Serial memory: command and address in on sck rising, data out on sck falling.
module sxs_eeprom_model (
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic spi_mosi,
	output logic     spi_miso
);
	logic [7:0]  mem [0:1023];
	logic [23:0] hdr;
	logic [7:0]  sh;
	int          nb;
	initial begin
		spi_miso = 1'b0;
		nb = 0;
	end
	// A new selection restarts the header count.
	always @(negedge spi_cs_n) nb = 0;
	// Released line shows the inverse of its last level, not a held value.
	always @(posedge spi_cs_n) spi_miso = ~spi_miso;
	// Header bits are taken MSB first.
	always @(posedge spi_sck) begin
		if (!spi_cs_n && nb < 24) hdr = {hdr[22:0], spi_mosi};
		if (!spi_cs_n) nb = nb + 1;
	end
	// Sequential read with 10-bit wrap; a wrong command returns junk.
	always @(negedge spi_sck) begin
		if (!spi_cs_n && nb >= 24) begin
			if ((nb - 24) % 8 == 0) sh = (hdr[23:16] == 8'h03) ? mem[hdr[9:0] + 10'((nb - 24) / 8)] : 8'(nb);
			spi_miso = sh[7 - (nb - 24) % 8];
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// Bench: memory image, button presses and a stalling payload sink.
module tb;
	logic        mclk, rstn, app_mode_select_pin, rc_clk, low_batt, eol_enable, spi_miso;
	logic        tx_ready, spi_cs_n, spi_sck, spi_mosi, reg_wr, tx_valid, tx_last, pll_lock;
	logic        rc_osc_en, sleeping, standalone;
	logic [3:0]  button_inputs;
	logic [2:0]  debounce_time;
	logic [5:0]  section_size;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_data, tx_data;
	logic [31:0] rnd;
	logic [47:0] cfg;
	logic [14:0] exp_reg [$];
	logic [8:0]  exp_tx [$];
	int          n_fail, samples_checked, a;
	int          slot_of [1:15] = '{0, 1, 4, 2, 5, 6, 10, 3, 7, 8, 11, 9, 12, 13, 14};
	sxs_seq #(.SCK_HALF(4), .DEB_MIN(4), .DEB_STEP(2), .RC_START(8)) dut (.mclk, .rstn,
		.app_mode_select_pin, .button_inputs, .rc_clk, .low_batt, .eol_enable, .debounce_time,
		.section_size, .spi_miso, .spi_cs_n, .spi_sck, .spi_mosi, .reg_wr, .reg_addr, .reg_data,
		.tx_valid, .tx_data, .tx_last, .tx_ready, .pll_lock, .rc_osc_en, .sleeping, .standalone);
	sxs_eeprom_model mem_m (.spi_cs_n, .spi_sck, .spi_mosi, .spi_miso);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_reg(input logic [14:0] exp, input logic [14:0] got);
		chk("reg_write", {1'b0, exp}, {1'b0, got});
	endtask
	task automatic chk_tx(input logic [8:0] exp, input logic [8:0] got);
		chk("tx_byte", {7'h00, exp}, {7'h00, got});
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Notes the register write and payload bytes one section should give.
	task automatic expect_frame(input int slot, input bit once);
		int b;
		int rep;
		b = 'h4d + slot * 16;
		if (!mem_m.mem[b][7]) return;
		exp_reg.push_back({mem_m.mem[b][6:0], mem_m.mem[b + 1]});
		rep = once ? 1 : (mem_m.mem[b + 3] == 8'hff ? 254 : int'(mem_m.mem[b + 3]));
		for (int r = 0; r < rep; r++)
			for (int i = 0; i < int'(mem_m.mem[b + 4]); i++)
				exp_tx.push_back({i == mem_m.mem[b + 4] - 1, mem_m.mem[b + 5 + i]});
	endtask
	// Waits, bounded, for the sleep flag to reach a level, then steps off the edge.
	task automatic wait_sleep(input logic lvl, input int lim);
		int k;
		k = 0;
		while (sleeping !== lvl && k < lim) begin
			@(posedge mclk);
			k++;
		end
		chk_flag("sleeping", lvl, sleeping);
		#2;
	endtask
	// Press, hold until done, then release; release must bring no memory traffic.
	task automatic press(input logic [3:0] code, input logic [2:0] dt);
		logic was_idle;
		debounce_time = dt;
		button_inputs = code;
		wait_sleep(1'b0, 40);
		wait_sleep(1'b1, 8000);
		chk_flag("drained", 1'b1, exp_tx.size() == 0 && exp_reg.size() == 0);
		button_inputs = 4'h0;
		was_idle = 1'b1;
		fork
			wait_sleep(1'b0, 40);
			while (sleeping !== 1'b0) @(posedge mclk);
		join
		while (sleeping !== 1'b1) begin
			@(posedge mclk);
			was_idle = was_idle & spi_cs_n;
		end
		chk_flag("release_idle", 1'b1, was_idle);
		#2;
	endtask
	// Each result on the pins takes the oldest note of its kind.
	always @(posedge mclk) begin
		if (rstn && reg_wr) chk_reg(exp_reg.size() ? exp_reg.pop_front() : 15'h7fff, {reg_addr, reg_data});
		if (rstn && tx_valid && tx_ready) chk_tx(exp_tx.size() ? exp_tx.pop_front() : 9'h1ff, {tx_last, tx_data});
	end
	// The sink stalls about a quarter of the time, so the buffer fills and refuses.
	always @(posedge mclk) begin
		#2;
		rnd = lfsr(rnd);
		tx_ready = rnd[1:0] != 2'b00;
	end
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// The oscillator only runs while the sequencer enables it.
	initial begin
		rc_clk = 1'b0;
		forever #100 rc_clk = rc_osc_en ? ~rc_clk : 1'b0;
	end
	initial begin
		repeat (90000) @(posedge mclk);
		n_fail++;
		$display("[ERR] watchdog expected finish seen timeout");
		give_verdict;
	end
	initial begin
		{rstn, app_mode_select_pin, button_inputs, low_batt, eol_enable} = 8'h40;
		{debounce_time, section_size, tx_ready, n_fail, samples_checked} = '0;
		section_size = 6'h0f;
		rnd = 32'h2560;
		for (int i = 0; i < 1024; i++) mem_m.mem[i] = 8'hff;
		cfg = 48'h8105_0511_900f;
		for (int i = 0; i < 6; i++) mem_m.mem[i] = cfg[47 - 8 * i -: 8];
		mem_m.mem['h4c] = 8'h85; // Lone last config byte must be ignored.
		for (int s = 0; s < 15; s++) begin
			a = 'h4d + s * 16;
			mem_m.mem[a] = (s == 6) ? 8'h17 : 8'h97; // Slot 6 holds a malformed command.
			mem_m.mem[a + 1] = 8'(s);
			mem_m.mem[a + 2] = 8'h95;
			mem_m.mem[a + 3] = (s == 5) ? 8'hff : 8'(s % 3 + 1);
			mem_m.mem[a + 4] = (s == 9) ? 8'h00 : 8'(s % 10 + 1);
			for (int i = 0; i < 11; i++) begin
				rnd = lfsr(rnd);
				mem_m.mem[a + 5 + i] = rnd[7:0];
			end
		end
		exp_reg.push_back({7'h01, 8'h05});
		exp_reg.push_back({7'h10, 8'h0f});
		repeat (12) @(posedge mclk);
		#2 rstn = 1'b1;
		wait_sleep(1'b1, 9000);
		chk_flag("standalone", 1'b1, standalone);
		app_mode_select_pin = 1'b0;
		for (int c = 1; c < 16; c++) begin
			expect_frame(slot_of[c], 1'b0);
			press(4'(c), 3'(c));
		end
		{eol_enable, low_batt} = 2'b11;
		expect_frame(slot_of[2], 1'b0);
		expect_frame(14, 1'b1);
		press(4'h2, 3'h1);
		rstn = 1'b0;
		@(posedge mclk);
		#2 rstn = 1'b1;
		repeat (200) @(posedge mclk);
		chk_flag("host_cs_idle", 1'b1, spi_cs_n);
		chk_flag("host_mode", 1'b0, standalone);
		give_verdict;
	end
endmodule
bind sxs_seq sxs_seq_properties chk_i (.mclk, .rstn, .button_inputs, .spi_cs_n, .spi_sck,
	.spi_mosi, .reg_wr, .tx_valid, .tx_data, .tx_last, .tx_ready, .pll_lock, .rc_osc_en,
	.sleeping, .standalone);
`default_nettype wire
